/* lfrsc_consts.vh */
`ifndef LFRSC_CONSTS_VH
`define LFRSC_CONSTS_VH

// clock rate and documented intervals in their own units
`define LFRSC_CLK_MHZ 10
`define LFRSC_OC_FILT_US 200
`define LFRSC_RETRY_MS 1400
`define LFRSC_SS_US 1300
`define LFRSC_OC_FILT_CYC (`LFRSC_OC_FILT_US * `LFRSC_CLK_MHZ)
`define LFRSC_RETRY_CYC (`LFRSC_RETRY_MS * 1000 * `LFRSC_CLK_MHZ)
`define LFRSC_SS_CYC (`LFRSC_SS_US * `LFRSC_CLK_MHZ)
`define LFRSC_TMR_W 24

// successive overcurrent shutdowns before the load is abnormal
`define LFRSC_OC_LIMIT 4'hC

// serial word framing
`define LFRSC_SER_BITS 4'h8
`define LFRSC_SER_MODE_BITS 4'h4
`define LFRSC_MODE_RST_A 4'h0
`define LFRSC_MODE_RST_B 4'hE

// serial register addresses
`define LFRSC_SA_GROUP 4'h1
`define LFRSC_SA_DIM_A 4'h2
`define LFRSC_SA_DIM_B 4'h3
`define LFRSC_SA_DIM_F 4'h4
`define LFRSC_SA_ON 4'h5
`define LFRSC_SA_SYS 4'h6

// on/off register fields
`define LFRSC_ON_REGL 0
`define LFRSC_ON_FLASH 1
`define LFRSC_ON_B 2
`define LFRSC_ON_A 3

// host bus byte addresses
`define LFRSC_BA_STATUS 8'h00
`define LFRSC_BA_IRQ_EN 8'h04
`define LFRSC_BA_IRQ_CLR 8'h08
`define LFRSC_BA_STATE 8'h0C
`define LFRSC_BA_SERREG 8'h10

// interrupt status bits
`define LFRSC_EV_W 5
`define LFRSC_EV_OC_STOP 0
`define LFRSC_EV_ABNORMAL 1
`define LFRSC_EV_THERMAL 2
`define LFRSC_EV_SER_WR 3
`define LFRSC_EV_RST_MODE 4

// regulator sequencer states
`define LFRSC_ST_OFF 2'h0
`define LFRSC_ST_RUN 2'h1
`define LFRSC_ST_WAIT 2'h2
`define LFRSC_ST_LOCK 2'h3

// synchroniser lane positions
`define LFRSC_SY_W 7
`define LFRSC_SY_SCLK 0
`define LFRSC_SY_SEN 1
`define LFRSC_SY_SDAT 2
`define LFRSC_SY_SLR 3
`define LFRSC_SY_OC 4
`define LFRSC_SY_THI 5
`define LFRSC_SY_TLO 6

`endif

/* lfrsc_ctrl.v */
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ps
`include "lfrsc_consts.vh"
// Overview of operation
// - regulator runs only while on/off register bit D4 (LSB) is 1
// - overcurrent held 200us stops regulator; restart after 1.4s wait
// - twelfth successive overcurrent shutdown latches abnormal load, regulator stays off
// - abnormal latch clears only when reset mode is selected
// - pump stops above 180C indication, resumes at below-160C indication
// - supply-loss pin low clears control registers, LEDs off, standby; abnormal latch and lock kept
// - power-up, supply-loss low or reset mode clear all control registers
// - serial writes applied in arrival order, any address order
// - clearing all on/off bits gives standby, other registers kept
// - channel switched on from standby waits 1.3ms soft start before lighting
// - enable low after four bits of mode 0H or EH selects reset mode
// - on/off bits: D1 group A, D2 group B, D3 flash, D4 regulator
module lfrsc_ctrl #(
    parameter [`LFRSC_TMR_W-1:0] RETRY_CYC = `LFRSC_RETRY_CYC,
    parameter [`LFRSC_TMR_W-1:0] SS_CYC = `LFRSC_SS_CYC
) (
    input wire ref_clk,
    input wire resetn,
    input wire clk_en,
    input wire ser_clk,
    input wire ser_en,
    input wire ser_data,
    input wire supply_loss_reset_n,
    input wire oc_ind,
    input wire temp_above_hi,
    input wire temp_below_lo,
    input wire [7:0] bus_addr,
    input wire [31:0] bus_wdata,
    input wire bus_wr,
    input wire bus_rd,
    output reg [31:0] bus_rdata,
    output reg irq,
    output reg regulated_output_pin,
    output reg pump_output,
    output reg led_a_on,
    output reg led_b_on,
    output reg flash_channel,
    output reg standby,
    output reg [3:0] group_sel,
    output reg [3:0] dim_a,
    output reg [3:0] dim_b,
    output reg [3:0] dim_flash,
    output reg [3:0] max_cur_sel
);

    localparam [`LFRSC_TMR_W-1:0] OC_FILT_CYC = `LFRSC_OC_FILT_CYC;

    // mode nibbles that select reset mode
    function is_reset_code;
        input [3:0] code;
        begin
            is_reset_code = (code == `LFRSC_MODE_RST_A) || (code == `LFRSC_MODE_RST_B);
        end
    endfunction

    // two-flop synchronisers for every pin from outside the clock domain
    wire [`LFRSC_SY_W-1:0] async_in;
    reg [`LFRSC_SY_W-1:0] sy1_reg;
    reg [`LFRSC_SY_W-1:0] sy2_reg;
    reg [`LFRSC_SY_W-1:0] sy3_reg;
    assign async_in = {temp_below_lo, temp_above_hi, oc_ind, supply_loss_reset_n,
                       ser_data, ser_en, ser_clk};
    genvar gi;
    generate
        for (gi = 0; gi < `LFRSC_SY_W; gi = gi + 1)
        begin : g_sync
            always @(posedge ref_clk or negedge resetn)
            begin
                if (!resetn)
                begin
                    sy1_reg[gi] <= 1'b0;
                    sy2_reg[gi] <= 1'b0;
                    sy3_reg[gi] <= 1'b0;
                end
                else if (clk_en)
                begin
                    sy1_reg[gi] <= async_in[gi];
                    sy2_reg[gi] <= sy1_reg[gi];
                    sy3_reg[gi] <= sy2_reg[gi];
                end
            end
        end
    endgenerate

    wire sclk_rise = sy2_reg[`LFRSC_SY_SCLK] & ~sy3_reg[`LFRSC_SY_SCLK];
    wire sen = sy2_reg[`LFRSC_SY_SEN];
    wire sen_fall = ~sy2_reg[`LFRSC_SY_SEN] & sy3_reg[`LFRSC_SY_SEN];
    wire supply_lost = ~sy2_reg[`LFRSC_SY_SLR];
    wire oc_s = sy2_reg[`LFRSC_SY_OC];
    wire thi_s = sy2_reg[`LFRSC_SY_THI];
    wire tlo_s = sy2_reg[`LFRSC_SY_TLO];

    // serial shifter and register state
    reg [7:0] shift_reg;
    reg [3:0] bit_cnt_reg;
    reg [3:0] group_reg;
    reg [3:0] dim_a_reg;
    reg [3:0] dim_b_reg;
    reg [3:0] dim_f_reg;
    reg [3:0] on_reg;
    reg [3:0] sys_reg;
    reg [1:0] st_reg;
    reg [1:0] st_next;
    reg [`LFRSC_TMR_W-1:0] tmr_reg;
    reg [`LFRSC_TMR_W-1:0] run_clean_reg;
    reg [3:0] oc_cnt_reg;
    reg abnormal_reg;
    reg hot_reg;
    reg [`LFRSC_TMR_W-1:0] ss_tmr_reg;
    reg ss_done_reg;
    reg [`LFRSC_EV_W-1:0] status_reg;
    reg [`LFRSC_EV_W-1:0] irq_en_reg;

    // end of frame decoding
    wire [3:0] mode_nib = (bit_cnt_reg == `LFRSC_SER_BITS) ? shift_reg[7:4] : shift_reg[3:0];
    wire rst_mode = sen_fall && (bit_cnt_reg >= `LFRSC_SER_MODE_BITS)
                    && is_reset_code(mode_nib);
    wire ser_wr = sen_fall && !rst_mode && (bit_cnt_reg == `LFRSC_SER_BITS);
    wire [3:0] wr_addr = shift_reg[7:4];
    wire [3:0] wr_data = shift_reg[3:0];
    wire ctl_clear = supply_lost || rst_mode;

    // shift bits in on serial clock rises while enable is high
    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            shift_reg <= 8'h00;
            bit_cnt_reg <= 4'h0;
        end
        else if (clk_en)
        begin
            if (!sen || supply_lost)
            begin
                bit_cnt_reg <= 4'h0;
            end
            else if (sclk_rise && bit_cnt_reg != `LFRSC_SER_BITS)
            begin
                shift_reg <= {shift_reg[6:0], sy2_reg[`LFRSC_SY_SDAT]};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
        end
    end

    // control registers, each frame applied as soon as it closes
    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            group_reg <= 4'h0;
            dim_a_reg <= 4'h0;
            dim_b_reg <= 4'h0;
            dim_f_reg <= 4'h0;
            on_reg <= 4'h0;
            sys_reg <= 4'h0;
        end
        else if (clk_en)
        begin
            if (ctl_clear)
            begin
                group_reg <= 4'h0;
                dim_a_reg <= 4'h0;
                dim_b_reg <= 4'h0;
                dim_f_reg <= 4'h0;
                on_reg <= 4'h0;
                sys_reg <= 4'h0;
            end
            else if (ser_wr)
            begin
                case (wr_addr)
                    `LFRSC_SA_GROUP: group_reg <= wr_data;
                    `LFRSC_SA_DIM_A: dim_a_reg <= wr_data;
                    `LFRSC_SA_DIM_B: dim_b_reg <= wr_data;
                    `LFRSC_SA_DIM_F: dim_f_reg <= wr_data;
                    `LFRSC_SA_ON: on_reg <= wr_data;
                    `LFRSC_SA_SYS: sys_reg <= wr_data;
                    default: on_reg <= on_reg;
                endcase
            end
        end
    end

    wire regl_req = on_reg[`LFRSC_ON_REGL];
    wire oc_hit = (st_reg == `LFRSC_ST_RUN) && (tmr_reg == OC_FILT_CYC - 1'b1) && oc_s;

    // regulator sequencer: run, stop on overcurrent, wait, retry or lock
    always @*
    begin
        st_next = st_reg;
        case (st_reg)
            `LFRSC_ST_OFF:
                if (regl_req)
                    st_next = `LFRSC_ST_RUN;
            `LFRSC_ST_RUN:
                if (!regl_req)
                    st_next = `LFRSC_ST_OFF;
                else if (oc_hit && oc_cnt_reg == `LFRSC_OC_LIMIT - 4'h1)
                    st_next = `LFRSC_ST_LOCK;
                else if (oc_hit)
                    st_next = `LFRSC_ST_WAIT;
            `LFRSC_ST_WAIT:
                if (!regl_req)
                    st_next = `LFRSC_ST_OFF;
                else if (tmr_reg == RETRY_CYC - 1'b1)
                    st_next = `LFRSC_ST_RUN;
            `LFRSC_ST_LOCK:
                st_next = `LFRSC_ST_LOCK;
            default:
                st_next = `LFRSC_ST_OFF;
        endcase
        if (rst_mode)
            st_next = `LFRSC_ST_OFF;
        else if (supply_lost && st_reg != `LFRSC_ST_LOCK)
            st_next = `LFRSC_ST_OFF;
    end

    // state, interval timer, successive-shutdown count and abnormal latch
    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_reg <= `LFRSC_ST_OFF;
            tmr_reg <= {`LFRSC_TMR_W{1'b0}};
            oc_cnt_reg <= 4'h0;
            abnormal_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            st_reg <= st_next;
            if (st_next != st_reg)
                tmr_reg <= {`LFRSC_TMR_W{1'b0}};
            else if (st_reg == `LFRSC_ST_RUN && !oc_s)
                tmr_reg <= {`LFRSC_TMR_W{1'b0}};
            else if (st_reg == `LFRSC_ST_RUN || st_reg == `LFRSC_ST_WAIT)
                tmr_reg <= tmr_reg + 1'b1;
            if (ctl_clear || st_next == `LFRSC_ST_OFF)
                oc_cnt_reg <= 4'h0;
            else if (oc_hit)
                oc_cnt_reg <= oc_cnt_reg + 4'h1;
            else if (st_reg == `LFRSC_ST_RUN && st_next == `LFRSC_ST_RUN
                     && run_clean_reg >= RETRY_CYC - 1'b1)
                oc_cnt_reg <= 4'h0;
            if (rst_mode)
                abnormal_reg <= 1'b0;
            else if (st_next == `LFRSC_ST_LOCK)
                abnormal_reg <= 1'b1;
        end
    end

    // clean-run timer: regulator running with no overcurrent at all
    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            run_clean_reg <= {`LFRSC_TMR_W{1'b0}};
        else if (clk_en)
        begin
            if (st_reg != `LFRSC_ST_RUN || oc_s)
                run_clean_reg <= {`LFRSC_TMR_W{1'b0}};
            else if (run_clean_reg != RETRY_CYC - 1'b1)
                run_clean_reg <= run_clean_reg + 1'b1;
        end
    end

    // thermal hysteresis and soft start
    wire any_led = on_reg[`LFRSC_ON_A] | on_reg[`LFRSC_ON_B] | on_reg[`LFRSC_ON_FLASH];
    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            hot_reg <= 1'b0;
            ss_tmr_reg <= {`LFRSC_TMR_W{1'b0}};
            ss_done_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            if (thi_s)
                hot_reg <= 1'b1;
            else if (tlo_s)
                hot_reg <= 1'b0;
            if (!any_led)
            begin
                ss_tmr_reg <= {`LFRSC_TMR_W{1'b0}};
                ss_done_reg <= 1'b0;
            end
            else if (!ss_done_reg)
            begin
                if (ss_tmr_reg == SS_CYC - 1'b1)
                    ss_done_reg <= 1'b1;
                else
                    ss_tmr_reg <= ss_tmr_reg + 1'b1;
            end
        end
    end

    // interrupt events, enable register, set wins over clear
    wire [`LFRSC_EV_W-1:0] ev;
    assign ev[`LFRSC_EV_OC_STOP] = oc_hit;
    assign ev[`LFRSC_EV_ABNORMAL] = (st_next == `LFRSC_ST_LOCK) && (st_reg != `LFRSC_ST_LOCK);
    assign ev[`LFRSC_EV_THERMAL] = thi_s && !hot_reg;
    assign ev[`LFRSC_EV_SER_WR] = ser_wr;
    assign ev[`LFRSC_EV_RST_MODE] = rst_mode;
    wire clr_hit = bus_wr && (bus_addr == `LFRSC_BA_IRQ_CLR);
    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            status_reg <= {`LFRSC_EV_W{1'b0}};
            irq_en_reg <= {`LFRSC_EV_W{1'b0}};
        end
        else if (clk_en)
        begin
            status_reg <= (status_reg & ~(clr_hit ? bus_wdata[`LFRSC_EV_W-1:0]
                          : {`LFRSC_EV_W{1'b0}})) | ev;
            if (bus_wr && bus_addr == `LFRSC_BA_IRQ_EN)
                irq_en_reg <= bus_wdata[`LFRSC_EV_W-1:0];
        end
    end

    // host read port, data one cycle after the strobe
    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            bus_rdata <= 32'h00000000;
        else if (clk_en)
        begin
            bus_rdata <= 32'h00000000;
            if (bus_rd)
            begin
                case (bus_addr)
                    `LFRSC_BA_STATUS: bus_rdata <= {27'h0000000, status_reg};
                    `LFRSC_BA_IRQ_EN: bus_rdata <= {27'h0000000, irq_en_reg};
                    `LFRSC_BA_STATE: bus_rdata <= {23'h000000, st_reg, oc_cnt_reg,
                                                  hot_reg, ss_done_reg, abnormal_reg};
                    `LFRSC_BA_SERREG: bus_rdata <= {8'h00, sys_reg, on_reg, dim_f_reg,
                                                   dim_b_reg, dim_a_reg, group_reg};
                    default: bus_rdata <= 32'h00000000;
                endcase
            end
        end
    end

    // registered outputs
    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            irq <= 1'b0;
            regulated_output_pin <= 1'b0;
            pump_output <= 1'b0;
            led_a_on <= 1'b0;
            led_b_on <= 1'b0;
            flash_channel <= 1'b0;
            standby <= 1'b1;
            group_sel <= 4'h0;
            dim_a <= 4'h0;
            dim_b <= 4'h0;
            dim_flash <= 4'h0;
            max_cur_sel <= 4'h0;
        end
        else if (clk_en)
        begin
            irq <= |(status_reg & irq_en_reg);
            regulated_output_pin <= (st_reg == `LFRSC_ST_RUN) && regl_req;
            pump_output <= any_led && !hot_reg;
            led_a_on <= on_reg[`LFRSC_ON_A] && ss_done_reg && !hot_reg;
            led_b_on <= on_reg[`LFRSC_ON_B] && ss_done_reg && !hot_reg;
            flash_channel <= on_reg[`LFRSC_ON_FLASH] && ss_done_reg && !hot_reg;
            standby <= !any_led && !regl_req;
            group_sel <= group_reg;
            dim_a <= dim_a_reg;
            dim_b <= dim_b_reg;
            dim_flash <= dim_f_reg;
            max_cur_sel <= sys_reg;
        end
    end

endmodule

/* lfrsc_ctrl_chk.sv */
`timescale 1ns/1ps
`include "lfrsc_consts.vh"
module lfrsc_ctrl_chk #(
    parameter [`LFRSC_TMR_W-1:0] RETRY_CYC = `LFRSC_RETRY_CYC,
    parameter [`LFRSC_TMR_W-1:0] SS_CYC = `LFRSC_SS_CYC
) (
    input wire ref_clk,
    input wire resetn,
    input wire supply_loss_reset_n,
    input wire oc_ind,
    input wire temp_above_hi,
    input wire temp_below_lo,
    input wire regulated_output_pin,
    input wire pump_output,
    input wire led_a_on,
    input wire led_b_on,
    input wire flash_channel,
    input wire standby,
    input wire [3:0] group_sel,
    input wire [3:0] dim_a,
    input wire [3:0] dim_b,
    input wire [3:0] dim_flash,
    input wire [3:0] max_cur_sel
);
    reg [11:0] oc_run_reg;
    reg [`LFRSC_TMR_W-1:0] ss_cnt_reg;
    wire lit = led_a_on | led_b_on | flash_channel;
    // overcurrent cycles while driving, and cycles out of standby
    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            oc_run_reg <= 12'h000;
            ss_cnt_reg <= 24'h000000;
        end
        else
        begin
            oc_run_reg <= (oc_ind && regulated_output_pin) ? oc_run_reg + 12'h001 : 12'h000;
            ss_cnt_reg <= standby ? 24'h000000 : ss_cnt_reg + 24'h000001;
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);
    property p_regl_off;
        standby [*3] |-> !regulated_output_pin;
    endproperty
    a_regl_off: assert property (p_regl_off)
        else $error("regulator driven in standby");
    property p_oc_max;
        oc_run_reg <= 12'h7DA;
    endproperty
    a_oc_max: assert property (p_oc_max)
        else $error("overcurrent not stopped in time");
    property p_oc_min;
        $fell(regulated_output_pin) && oc_ind |-> oc_run_reg >= 12'h7C6;
    endproperty
    a_oc_min: assert property (p_oc_min)
        else $error("overcurrent stop too early");
    property p_hot;
        (temp_above_hi && !temp_below_lo) [*6] |-> !pump_output && !lit;
    endproperty
    a_hot: assert property (p_hot)
        else $error("output kept while hot");
    property p_hyst;
        (temp_above_hi && !temp_below_lo) [*6] ##1 !temp_below_lo [*8] |-> !pump_output;
    endproperty
    a_hyst: assert property (p_hyst)
        else $error("pump resumed before cooling");
    property p_sl_dark;
        !supply_loss_reset_n [*6] |-> standby && !regulated_output_pin && !pump_output && !lit;
    endproperty
    a_sl_dark: assert property (p_sl_dark)
        else $error("outputs alive in supply loss");
    property p_sl_clear;
        !supply_loss_reset_n [*6] |-> {group_sel, dim_a, dim_b, dim_flash, max_cur_sel} == 0;
    endproperty
    a_sl_clear: assert property (p_sl_clear)
        else $error("registers kept in supply loss");
    property p_soft;
        $rose(lit) |-> ss_cnt_reg >= SS_CYC - 3;
    endproperty
    a_soft: assert property (p_soft)
        else $error("lamp lit before soft start");
endmodule
bind lfrsc_ctrl lfrsc_ctrl_chk #(.RETRY_CYC(RETRY_CYC), .SS_CYC(SS_CYC)) i_lfrsc_ctrl_chk (
    .ref_clk(ref_clk), .resetn(resetn), .supply_loss_reset_n(supply_loss_reset_n),
    .oc_ind(oc_ind), .temp_above_hi(temp_above_hi), .temp_below_lo(temp_below_lo),
    .regulated_output_pin(regulated_output_pin), .pump_output(pump_output),
    .led_a_on(led_a_on), .led_b_on(led_b_on), .flash_channel(flash_channel),
    .standby(standby), .group_sel(group_sel), .dim_a(dim_a), .dim_b(dim_b),
    .dim_flash(dim_flash), .max_cur_sel(max_cur_sel));

/* lfrsc_ctrl_tb.sv */
`timescale 1ns/1ps
`include "lfrsc_consts.vh"
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
    $display("unexpected %s: expected %h seen %h", n, e, g); end end
module lfrsc_ctrl_tb;
    localparam [`LFRSC_TMR_W-1:0] RETRY = 24'h000032;
    localparam [`LFRSC_TMR_W-1:0] SS = 24'h000014;
    logic ref_clk, resetn, supply_loss_reset_n, oc_ind, temp_above_hi, temp_below_lo;
    logic bus_wr, bus_rd, irq, regulated_output_pin, pump_output, led_a_on, led_b_on;
    logic flash_channel, standby, ser_clk, ser_en, ser_data;
    logic [7:0] bus_addr;
    logic [31:0] bus_wdata, bus_rdata;
    logic [3:0] group_sel, dim_a, dim_b, dim_flash, max_cur_sel;
    integer n_errors = 0, n_tests = 0, cyc = 0, k, t;
    lfrsc_mcu_model i_lfrsc_mcu_model (.ser_clk(ser_clk), .ser_en(ser_en), .ser_data(ser_data));
    lfrsc_ctrl #(.RETRY_CYC(RETRY), .SS_CYC(SS)) i_lfrsc_ctrl (.ref_clk(ref_clk),
        .resetn(resetn), .clk_en(1'b1), .ser_clk(ser_clk), .ser_en(ser_en), .ser_data(ser_data),
        .supply_loss_reset_n(supply_loss_reset_n), .oc_ind(oc_ind), .temp_above_hi(temp_above_hi),
        .temp_below_lo(temp_below_lo), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .irq(irq),
        .regulated_output_pin(regulated_output_pin), .pump_output(pump_output),
        .led_a_on(led_a_on), .led_b_on(led_b_on), .flash_channel(flash_channel),
        .standby(standby), .group_sel(group_sel), .dim_a(dim_a), .dim_b(dim_b),
        .dim_flash(dim_flash), .max_cur_sel(max_cur_sel));
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic tick(input integer n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge ref_clk);
        bus_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge ref_clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge ref_clk);
        bus_rd <= 1'b0;
        @(negedge ref_clk);
        `CHK("bus_rdata", e, bus_rdata & m)
    endtask
    task automatic fr(input logic [7:0] w, input integer nb);
        i_lfrsc_mcu_model.send(w, nb);
        tick(8);
    endtask
    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    // cut a hang short
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 80000)
        begin
            n_errors++;
            report_and_stop;
        end
    end
    initial
    begin
        {resetn, oc_ind, temp_above_hi, bus_wr, bus_rd} = 5'h00;
        {supply_loss_reset_n, temp_below_lo} = 2'h3;
        bus_addr = 8'h00;
        bus_wdata = 32'h00000000;
        tick(5);
        resetn <= 1'b1;
        tick(3);
        rd(`LFRSC_BA_SERREG, 32'hFFFFFFFF, 32'h00000000);
        rd(8'h20, 32'hFFFFFFFF, 32'h00000000);
        `CHK("standby", 1'b1, standby)
        $display("reset test done");
        fr(8'h13, 8);
        fr(8'h25, 8);
        fr(8'h3A, 8);
        fr(8'h4C, 8);
        fr(8'h6E, 8);
        fr(8'h21, 8);
        fr(8'h2F, 7);
        rd(`LFRSC_BA_SERREG, 32'hFFFFFFFF, 32'h00E0CA13);
        `CHK("regs", 20'h31ACE, {group_sel, dim_a, dim_b, dim_flash, max_cur_sel})
        wr(`LFRSC_BA_IRQ_EN, 32'h00000008);
        tick(2);
        `CHK("irq", 1'b1, irq)
        wr(`LFRSC_BA_IRQ_EN, 32'h00000000);
        tick(2);
        `CHK("irq", 1'b0, irq)
        wr(`LFRSC_BA_IRQ_EN, 32'h00000008);
        wr(`LFRSC_BA_IRQ_CLR, 32'h0000001F);
        wr(`LFRSC_BA_STATUS, 32'h0000001F);
        tick(2);
        `CHK("irq", 1'b0, irq)
        rd(`LFRSC_BA_STATUS, 32'h0000001F, 32'h00000000);
        fr(8'hE5, 8);
        rd(`LFRSC_BA_SERREG, 32'hFFFFFFFF, 32'h00000000);
        rd(`LFRSC_BA_STATUS, 32'h00000010, 32'h00000010);
        $display("register test done");
        fr(8'h2F, 8);
        for (k = 0; k < 3; k++)
        begin
            fr((8'h08 >> k) | 8'h50, 8);
            `CHK("lamps early", 3'h0, {led_a_on, led_b_on, flash_channel})
            tick(SS + 4);
            `CHK("lamps", {1'b1, 3'h4 >> k}, {pump_output, led_a_on, led_b_on, flash_channel})
            fr(8'h50, 8);
            `CHK("dark", 4'h1, {pump_output, led_a_on, flash_channel, standby})
        end
        rd(`LFRSC_BA_SERREG, 32'hFFFFFFFF, 32'h000000F0);
        fr(8'h58, 8);
        tick(SS + 4);
        temp_below_lo <= 1'b0;
        temp_above_hi <= 1'b1;
        tick(8);
        `CHK("hot", 2'h0, {pump_output, led_a_on})
        temp_above_hi <= 1'b0;
        tick(20);
        `CHK("cooling", 2'h0, {pump_output, led_a_on})
        rd(`LFRSC_BA_STATUS, 32'h00000004, 32'h00000004);
        temp_below_lo <= 1'b1;
        tick(8);
        `CHK("cool", 2'h3, {pump_output, led_a_on})
        fr(8'h51, 8);
        tick(3);
        `CHK("regulator", 1'b1, regulated_output_pin)
        $display("lamp test done");
        for (k = 0; k <= 12; k++)
        begin
            oc_ind <= 1'b1;
            t = 0;
            while (regulated_output_pin === 1'b1 && t < 3000)
            begin
                tick(1);
                t++;
            end
            `CHK("on time ok", 1'b1, t >= 1995 && t <= 2010)
            oc_ind <= (k != 0);
            t = 0;
            while (regulated_output_pin !== 1'b1 && t < 200)
            begin
                tick(1);
                t++;
            end
            if (k < 12)
                `CHK("retry ok", 1'b1, t >= RETRY - 2 && t <= RETRY + 6)
            if (k == 0)
            begin
                rd(`LFRSC_BA_STATE, 32'h00000078, 32'h00000008);
                tick(RETRY + 10);
                rd(`LFRSC_BA_STATE, 32'h00000078, 32'h00000000);
            end
        end
        `CHK("locked off", 1'b0, regulated_output_pin)
        rd(`LFRSC_BA_STATE, 32'h00000181, 32'h00000181);
        rd(`LFRSC_BA_STATUS, 32'h00000003, 32'h00000003);
        oc_ind <= 1'b0;
        supply_loss_reset_n <= 1'b0;
        tick(8);
        `CHK("supply loss", 3'h4, {standby, pump_output, led_a_on})
        rd(`LFRSC_BA_SERREG, 32'hFFFFFFFF, 32'h00000000);
        supply_loss_reset_n <= 1'b1;
        fr(8'h51, 8);
        tick(4);
        `CHK("still locked", 1'b0, regulated_output_pin)
        rd(`LFRSC_BA_STATE, 32'h00000001, 32'h00000001);
        fr(8'h00, 4);
        rd(`LFRSC_BA_STATE, 32'h00000181, 32'h00000000);
        fr(8'h51, 8);
        tick(4);
        `CHK("regulator back", 1'b1, regulated_output_pin)
        fr(8'h50, 8);
        tick(4);
        `CHK("regulator off", 1'b0, regulated_output_pin)
        $display("regulator test done");
        report_and_stop;
    end
endmodule

/* lfrsc_mcu_model.sv */
`timescale 1ns/1ps
module lfrsc_mcu_model (
    output logic ser_clk,
    output logic ser_en,
    output logic ser_data
);
    // clock stands low and data at pull-down level outside frames
    initial
    begin
        ser_clk = 1'b0;
        ser_en = 1'b0;
        ser_data = 1'b0;
    end
    // one framed word, msb first, 800 ns serial clock
    task automatic send(input logic [7:0] w, input integer nb);
        integer i;
        #37;
        ser_en = 1'b1;
        for (i = 0; i < nb; i++)
        begin
            ser_data = w[7-i];
            #400 ser_clk = 1'b1;
            #400 ser_clk = 1'b0;
        end
        #400 ser_en = 1'b0;
        ser_data = 1'b0;
    endtask
endmodule
